// ### hw/rlcr_map.vh
// register offsets, field positions and reset values of the radio link config bank
`ifndef RLCR_MAP_VH
`define RLCR_MAP_VH
`define RLCR_ADDR_W          32
`define RLCR_OFF_PWR_PHASE   32'h40000084
`define RLCR_OFF_ADV_CHMAP   32'h40000090
`define RLCR_OFF_ADV_SPACE   32'h400000A0
`define RLCR_OFF_ACT_SCAN    32'h400000A4
`define RLCR_OFF_PUB_BASE    32'h400000B0
`define RLCR_OFF_PRIV_BASE   32'h400000B4
`define RLCR_OFF_LIST_CNT    32'h400000B8
`define RLCR_OFF_CIPH_CTRL   32'h400000C0
`define RLCR_OFF_KEY0        32'h400000C4
`define RLCR_OFF_KEY1        32'h400000C8
`define RLCR_OFF_KEY2        32'h400000CC
`define RLCR_OFF_KEY3        32'h400000D0
`define RLCR_OFF_BLOCK_BASE  32'h400000D4
`define RLCR_OFF_TX_TAG      32'h400000D8
`define RLCR_OFF_RX_TAG      32'h400000DC
`define RLCR_OFF_TEST_CTRL   32'h400000E0
`define RLCR_OFF_TX_TOTAL    32'h400000E4
`define RLCR_OFF_RX_TOTAL    32'h400000E8
`define RLCR_RST_PWR_DN      4'h3
`define RLCR_RST_PWR_UP      8'hD2
`define RLCR_RST_CHMAP       3'h7
`define RLCR_RST_SCAN        9'h001
`define RLCR_BIT_START       0
`define RLCR_BIT_MODE        1
`define RLCR_BIT_ENDLESS_RX  31
`define RLCR_BIT_RX_CNT_EN   27
`define RLCR_BIT_ENDLESS_TX  15
`define RLCR_BIT_LEN_SEL     14
`define RLCR_BIT_PRBS_KIND   13
`define RLCR_BIT_PLD_SEL     12
`define RLCR_BIT_TX_CNT_EN   11
`define RLCR_TEST_CTRL_MASK  32'h8800F9FF
`endif

// ### hw/rlcr_regs.v
// register bank of the low energy radio link core
`timescale 1ns/100ps
`include "rlcr_map.vh"
//Function
// [RULE1] power-down extension, 4 bits, default 3
// [RULE2] power-up length, 8 bits, default 210
// [RULE3] channel 37+i used when map bit set
// [RULE4] advertising spacing from 14-bit field
// [RULE5] read-only scan counters, reset to one
// [RULE6] public list parse starts at pointer
// [RULE7] private list parse starts at pointer
// [RULE8] private count high byte, public low
// [RULE9] start bit launches; mode selects decrypt
// [RULE10] start clears on cipher completion
// [RULE11] key assembled from four words, low first
// [RULE12] cipher block fetched from pointer
// [RULE13] read-only transmit integrity tag
// [RULE14] read-only receive integrity tag
// [RULE15] endless receive window in test mode
// [RULE16] count good receptions, report on abort
// [RULE17] endless transmit payload in test mode
// [RULE18] length from descriptor or test field
// [RULE19] prbs9 or prbs15 by kind bit
// [RULE20] payload from structure or prbs
// [RULE21] count transmissions, report on abort
// [RULE22] test length used only when selected
// [RULE23] read-only tx and rx totals
// [RULE24] writing zero to start ignored
// [RULE25] test bits inert outside test mode
module rlcr_regs
(
  input  wire         core_clk_i,
  input  wire         rst_i,
  input  wire [31:0]  addr_i,
  input  wire [31:0]  wdata_i,
  input  wire         wr_i,
  input  wire         rd_i,
  output reg  [31:0]  rdata_o,
  input  wire         cipher_done_i,
  input  wire [8:0]   scan_retreat_init_i,
  input  wire [8:0]   scan_ceiling_i,
  input  wire         scan_update_i,
  input  wire [31:0]  tx_tag_i,
  input  wire         tx_tag_valid_i,
  input  wire [31:0]  rx_tag_i,
  input  wire         rx_tag_valid_i,
  input  wire         rf_test_mode_i,
  input  wire         tx_packet_sent_i,
  input  wire         rx_packet_good_i,
  input  wire         rf_abort_i,
  input  wire [8:0]   descriptor_payload_len_i,
  output wire [3:0]   tx_power_down_len_o,
  output wire [7:0]   tx_power_up_len_o,
  output wire [2:0]   advertising_channel_map_o,
  output wire [13:0]  adv_packet_spacing_o,
  output wire [15:0]  public_list_base_o,
  output wire [15:0]  private_list_base_o,
  output wire [7:0]   private_entry_count_o,
  output wire [7:0]   public_entry_count_o,
  output wire         cipher_start_o,
  output wire         cipher_decrypt_o,
  output wire [127:0] cipher_key_o,
  output wire [15:0]  cipher_block_base_o,
  output wire         endless_receive_window_o,
  output wire         endless_transmit_o,
  output wire         pseudo_random_kind_o,
  output wire         test_payload_select_o,
  output wire [8:0]   tx_payload_len_o,
  output reg  [31:0]  tx_packet_total_o,
  output reg  [31:0]  rx_good_packet_total_o
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [3:0]  pwr_dn;
  reg  [7:0]  pwr_up;
  reg  [2:0]  chmap;
  reg  [13:0] adv_space;
  reg  [8:0]  scan_init;
  reg  [8:0]  scan_ceil;
  reg  [15:0] pub_base;
  reg  [15:0] priv_base;
  reg  [15:0] list_cnt;
  reg         start;
  reg         mode;
  reg  [31:0] key0;
  reg  [31:0] key1;
  reg  [31:0] key2;
  reg  [31:0] key3;
  reg  [15:0] block_base;
  reg  [31:0] tx_tag;
  reg  [31:0] rx_tag;
  reg  [31:0] test_ctrl;
  reg  [31:0] tx_run;
  reg  [31:0] rx_run;
  reg  [31:0] next_rdata;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire wr_ctrl  = wr_i && (addr_i == `RLCR_OFF_CIPH_CTRL);
  wire wr_pwr   = wr_i && (addr_i == `RLCR_OFF_PWR_PHASE);
  wire wr_chmap = wr_i && (addr_i == `RLCR_OFF_ADV_CHMAP);
  wire wr_space = wr_i && (addr_i == `RLCR_OFF_ADV_SPACE);
  wire wr_pub   = wr_i && (addr_i == `RLCR_OFF_PUB_BASE);
  wire wr_priv  = wr_i && (addr_i == `RLCR_OFF_PRIV_BASE);
  wire wr_cnt   = wr_i && (addr_i == `RLCR_OFF_LIST_CNT);
  wire wr_key0  = wr_i && (addr_i == `RLCR_OFF_KEY0);
  wire wr_key1  = wr_i && (addr_i == `RLCR_OFF_KEY1);
  wire wr_key2  = wr_i && (addr_i == `RLCR_OFF_KEY2);
  wire wr_key3  = wr_i && (addr_i == `RLCR_OFF_KEY3);
  wire wr_block = wr_i && (addr_i == `RLCR_OFF_BLOCK_BASE);
  wire wr_test  = wr_i && (addr_i == `RLCR_OFF_TEST_CTRL);

  // ----------------------------------------------------------------
  // power phase lengths
  // ----------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      // [RULE1] power-down default
      pwr_dn <= `RLCR_RST_PWR_DN;
      // [RULE2] power-up default
      pwr_up <= `RLCR_RST_PWR_UP;
    end
    else if (wr_pwr)
    begin
      pwr_dn <= wdata_i[11:8];
      pwr_up <= wdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // advertising setup
  // ----------------------------------------------------------------
  // [RULE3] all channels on
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      chmap <= `RLCR_RST_CHMAP;
    else if (wr_chmap)
      chmap <= wdata_i[2:0];
  end

  // [RULE4] spacing field
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      adv_space <= 14'h0000;
    else if (wr_space)
      adv_space <= wdata_i[13:0];
  end

  // ----------------------------------------------------------------
  // list pointers and counts
  // ----------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      pub_base <= 16'h0000;
    else if (wr_pub)
      pub_base <= wdata_i[15:0];
  end

  always @(posedge core_clk_i)
  begin
    if (rst_i)
      priv_base <= 16'h0000;
    else if (wr_priv)
      priv_base <= wdata_i[15:0];
  end

  always @(posedge core_clk_i)
  begin
    if (rst_i)
      list_cnt <= 16'h0000;
    else if (wr_cnt)
      list_cnt <= wdata_i[15:0];
  end

  // ----------------------------------------------------------------
  // cipher setup
  // ----------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      mode <= 1'b0;
    else if (wr_ctrl)
      mode <= wdata_i[`RLCR_BIT_MODE];
  end

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      key0 <= 32'h00000000;
      key1 <= 32'h00000000;
      key2 <= 32'h00000000;
      key3 <= 32'h00000000;
    end
    else
    begin
      if (wr_key0)
        key0 <= wdata_i;
      if (wr_key1)
        key1 <= wdata_i;
      if (wr_key2)
        key2 <= wdata_i;
      if (wr_key3)
        key3 <= wdata_i;
    end
  end

  always @(posedge core_clk_i)
  begin
    if (rst_i)
      block_base <= 16'h0000;
    else if (wr_block)
      block_base <= wdata_i[15:0];
  end

  // ----------------------------------------------------------------
  // test control
  // ----------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      test_ctrl <= 32'h00000000;
    else if (wr_test)
      test_ctrl <= wdata_i & `RLCR_TEST_CTRL_MASK;
  end

  // ----------------------------------------------------------------
  // cipher start bit
  // ----------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      start <= 1'b0;
    // [RULE9] write one starts
    else if (wr_ctrl && wdata_i[`RLCR_BIT_START])
      start <= 1'b1;
    // [RULE10] clear on done
    else if (cipher_done_i)
      start <= 1'b0;
    // [RULE24] zero write ignored
  end

  // ----------------------------------------------------------------
  // hardware captured status
  // ----------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      // [RULE5] scan counters read one
      scan_init <= `RLCR_RST_SCAN;
      scan_ceil <= `RLCR_RST_SCAN;
      tx_tag    <= 32'h00000000;
      rx_tag    <= 32'h00000000;
    end
    else
    begin
      if (scan_update_i)
      begin
        scan_init <= scan_retreat_init_i;
        scan_ceil <= scan_ceiling_i;
      end
      // [RULE13] capture transmit tag
      if (tx_tag_valid_i)
        tx_tag <= tx_tag_i;
      // [RULE14] capture receive tag
      if (rx_tag_valid_i)
        rx_tag <= rx_tag_i;
    end
  end

  // ----------------------------------------------------------------
  // test mode packet counters
  // ----------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      tx_run                 <= 32'h00000000;
      rx_run                 <= 32'h00000000;
      tx_packet_total_o      <= 32'h00000000;
      rx_good_packet_total_o <= 32'h00000000;
    end
    else if (rf_test_mode_i)
    begin
      // [RULE21] count and report tx
      if (test_ctrl[`RLCR_BIT_TX_CNT_EN])
      begin
        if (rf_abort_i)
          tx_packet_total_o <= tx_run + {31'h0, tx_packet_sent_i};
        else if (tx_packet_sent_i)
          tx_run <= tx_run + 32'h00000001;
      end
      // [RULE16] count and report rx
      if (test_ctrl[`RLCR_BIT_RX_CNT_EN])
      begin
        if (rf_abort_i)
          rx_good_packet_total_o <= rx_run + {31'h0, rx_packet_good_i};
        else if (rx_packet_good_i)
          rx_run <= rx_run + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs to the link core
  // ----------------------------------------------------------------
  assign tx_power_down_len_o       = pwr_dn;
  assign tx_power_up_len_o         = pwr_up;
  assign advertising_channel_map_o = chmap;
  assign adv_packet_spacing_o      = adv_space;
  // [RULE6] public base
  assign public_list_base_o        = pub_base;
  // [RULE7] private base
  assign private_list_base_o       = priv_base;
  // [RULE8] entry counts split
  assign private_entry_count_o     = list_cnt[15:8];
  assign public_entry_count_o      = list_cnt[7:0];
  assign cipher_start_o            = start;
  assign cipher_decrypt_o          = mode;
  // [RULE11] key word order
  assign cipher_key_o              = {key3, key2, key1, key0};
  // [RULE12] block pointer
  assign cipher_block_base_o       = block_base;
  // [RULE15] endless rx gated
  assign endless_receive_window_o  = rf_test_mode_i & test_ctrl[`RLCR_BIT_ENDLESS_RX];
  // [RULE17] endless tx gated
  assign endless_transmit_o        = rf_test_mode_i & test_ctrl[`RLCR_BIT_ENDLESS_TX];
  // [RULE19] prbs kind
  assign pseudo_random_kind_o      = rf_test_mode_i & test_ctrl[`RLCR_BIT_PRBS_KIND];
  // [RULE20] payload source
  assign test_payload_select_o     = rf_test_mode_i & test_ctrl[`RLCR_BIT_PLD_SEL];
  // [RULE18] [RULE22] [RULE25] length source
  assign tx_payload_len_o = (rf_test_mode_i && test_ctrl[`RLCR_BIT_LEN_SEL]) ?
                            test_ctrl[8:0] : descriptor_payload_len_i;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always @*
  begin
    next_rdata = 32'h00000000;
    case (addr_i)
      `RLCR_OFF_PWR_PHASE:  next_rdata = {20'h0, pwr_dn, pwr_up};
      `RLCR_OFF_ADV_CHMAP:  next_rdata = {29'h0, chmap};
      `RLCR_OFF_ADV_SPACE:  next_rdata = {18'h0, adv_space};
      `RLCR_OFF_ACT_SCAN:   next_rdata = {7'h0, scan_init, 7'h0, scan_ceil};
      `RLCR_OFF_PUB_BASE:   next_rdata = {16'h0, pub_base};
      `RLCR_OFF_PRIV_BASE:  next_rdata = {16'h0, priv_base};
      `RLCR_OFF_LIST_CNT:   next_rdata = {16'h0, list_cnt};
      `RLCR_OFF_CIPH_CTRL:  next_rdata = {30'h0, mode, start};
      `RLCR_OFF_KEY0:       next_rdata = key0;
      `RLCR_OFF_KEY1:       next_rdata = key1;
      `RLCR_OFF_KEY2:       next_rdata = key2;
      `RLCR_OFF_KEY3:       next_rdata = key3;
      `RLCR_OFF_BLOCK_BASE: next_rdata = {16'h0, block_base};
      `RLCR_OFF_TX_TAG:     next_rdata = tx_tag;
      `RLCR_OFF_RX_TAG:     next_rdata = rx_tag;
      `RLCR_OFF_TEST_CTRL:  next_rdata = test_ctrl;
      // [RULE23] totals readable
      `RLCR_OFF_TX_TOTAL:   next_rdata = tx_packet_total_o;
      `RLCR_OFF_RX_TOTAL:   next_rdata = rx_good_packet_total_o;
      default:              next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge core_clk_i)
  begin
    if (rst_i)
      rdata_o <= 32'h00000000;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= 32'h00000000;
  end

endmodule

// ### testbench/rlcr_regs_sva.sv
// concurrent checks of the radio link config bank
`timescale 1ns/100ps
`include "rlcr_map.vh"
module rlcr_sva
(
  input wire         core_clk_i,
  input wire         rst_i,
  input wire [31:0]  addr_i,
  input wire [31:0]  wdata_i,
  input wire         wr_i,
  input wire         rd_i,
  input wire [31:0]  rdata_o,
  input wire         cipher_done_i,
  input wire [31:0]  tx_tag_i,
  input wire         tx_tag_valid_i,
  input wire         rf_test_mode_i,
  input wire [8:0]   descriptor_payload_len_i,
  input wire         cipher_start_o,
  input wire         cipher_decrypt_o,
  input wire [127:0] cipher_key_o,
  input wire         endless_receive_window_o,
  input wire         endless_transmit_o,
  input wire [8:0]   tx_payload_len_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire cw = wr_i && addr_i == `RLCR_OFF_CIPH_CTRL;
  a_start_set: assert property (cw && wdata_i[0] |=> cipher_start_o)
    else $error("start bit not set by write");
  a_mode_set: assert property (cw |=> cipher_decrypt_o == $past(wdata_i[1]))
    else $error("mode bit not taken from write");
  a_start_clear: assert property (cipher_done_i && !(cw && wdata_i[0]) |=> !cipher_start_o)
    else $error("start bit not cleared on done");
  a_zero_start: assert property (cw && !wdata_i[0] && !cipher_done_i |=> $stable(cipher_start_o))
    else $error("zero write changed start bit");
  a_test_inert: assert property (!rf_test_mode_i |-> !endless_receive_window_o && !endless_transmit_o)
    else $error("test bit active outside test mode");
  a_len_desc: assert property (!rf_test_mode_i |-> tx_payload_len_o == descriptor_payload_len_i)
    else $error("length not from descriptor");
  a_key_low: assert property (wr_i && addr_i == `RLCR_OFF_KEY0 |=> cipher_key_o[31:0] == $past(wdata_i))
    else $error("key word0 not in low key bits");
  a_tag_read: assert property (tx_tag_valid_i ##1 (rd_i && addr_i == `RLCR_OFF_TX_TAG) |=> rdata_o == $past(tx_tag_i, 2))
    else $error("tx tag read mismatch");
endmodule
bind rlcr_regs rlcr_sva u_sva
(
  .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .cipher_done_i(cipher_done_i), .tx_tag_i(tx_tag_i),
  .tx_tag_valid_i(tx_tag_valid_i), .rf_test_mode_i(rf_test_mode_i),
  .descriptor_payload_len_i(descriptor_payload_len_i), .cipher_start_o(cipher_start_o),
  .cipher_decrypt_o(cipher_decrypt_o), .cipher_key_o(cipher_key_o),
  .endless_receive_window_o(endless_receive_window_o),
  .endless_transmit_o(endless_transmit_o), .tx_payload_len_o(tx_payload_len_o)
);

// ### testbench/test_radio_link_config_regs.sv
// self-checking bench of the radio link config bank
`timescale 1ns/100ps
`include "rlcr_map.vh"
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, v); end end
module test_radio_link_config_regs;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         wr = 1'b0, rd = 1'b0, done = 1'b0, tm = 1'b0, ab = 1'b0;
  logic         su = 1'b0, txv = 1'b0, rxv = 1'b0, txs = 1'b0, rxg = 1'b0;
  logic [31:0]  a = 32'h0, d = 32'h0, txt = 32'h0, rxt = 32'h0;
  logic [8:0]   sri = 9'h0, sc = 9'h0, dl = 9'h155;
  wire  [31:0]  rdata, txtot, rxtot;
  wire  [127:0] key;
  wire  [15:0]  pub, priv, blk;
  wire  [13:0]  spc;
  wire  [8:0]   len;
  wire  [7:0]   pu, npr, npu;
  wire  [3:0]   pdn, tst;
  wire  [2:0]   chm;
  wire          st, dec;
  int           error_cnt = 0, tests_run = 0, cyc = 0;
  localparam logic [31:0] adr_tab [12] = '{`RLCR_OFF_PWR_PHASE, `RLCR_OFF_ADV_CHMAP,
    `RLCR_OFF_ADV_SPACE, `RLCR_OFF_PUB_BASE, `RLCR_OFF_PRIV_BASE, `RLCR_OFF_LIST_CNT,
    `RLCR_OFF_KEY0, `RLCR_OFF_KEY1, `RLCR_OFF_KEY2, `RLCR_OFF_KEY3, `RLCR_OFF_BLOCK_BASE,
    `RLCR_OFF_TEST_CTRL};
  localparam logic [31:0] msk_tab [12] = '{32'hFFF, 32'h7, 32'h3FFF, 32'hFFFF, 32'hFFFF,
    32'hFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFF, 32'h8800F9FF};
  localparam logic [31:0] rst_tab [12] = '{32'h3D2, 32'h7, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  always #5 clk = ~clk;
  rlcr_regs u_dut
  (
    .core_clk_i(clk), .rst_i(rst), .addr_i(a), .wdata_i(d), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .cipher_done_i(done), .scan_retreat_init_i(sri), .scan_ceiling_i(sc),
    .scan_update_i(su), .tx_tag_i(txt), .tx_tag_valid_i(txv), .rx_tag_i(rxt),
    .rx_tag_valid_i(rxv), .rf_test_mode_i(tm), .tx_packet_sent_i(txs),
    .rx_packet_good_i(rxg), .rf_abort_i(ab), .descriptor_payload_len_i(dl),
    .tx_power_down_len_o(pdn), .tx_power_up_len_o(pu), .advertising_channel_map_o(chm),
    .adv_packet_spacing_o(spc), .public_list_base_o(pub), .private_list_base_o(priv),
    .private_entry_count_o(npr), .public_entry_count_o(npu), .cipher_start_o(st),
    .cipher_decrypt_o(dec), .cipher_key_o(key), .cipher_block_base_o(blk),
    .endless_receive_window_o(tst[3]), .endless_transmit_o(tst[2]),
    .pseudo_random_kind_o(tst[1]), .test_payload_select_o(tst[0]),
    .tx_payload_len_o(len), .tx_packet_total_o(txtot), .rx_good_packet_total_o(rxtot)
  );
  function automatic logic [31:0] pat(input int i);
    pat = {4{8'h81 + 8'(i)}};
  endfunction
  task automatic wr_reg(input logic [31:0] ad, input logic [31:0] dt);
    @(posedge clk);
    a <= ad;
    d <= dt;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [31:0] ad, input logic [31:0] ex);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", ex, rdata)
  endtask
  task automatic pulse_clk();
    @(posedge clk);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 12; i++)
      rd_chk(adr_tab[i], rst_tab[i]);
    rd_chk(`RLCR_OFF_ACT_SCAN, 32'h00010001);
    `CHK("reset outs", {4'h3, 8'hD2, 3'h7}, {pdn, pu, chm})
    rd_chk(32'h40000088, 32'h0);
  endtask
  task automatic t_rw();
    for (int i = 0; i < 12; i++)
      wr_reg(adr_tab[i], pat(i));
    for (int i = 0; i < 12; i++)
      rd_chk(adr_tab[i], pat(i) & msk_tab[i]);
    `CHK("pwr", pat(0) & 32'hFFF, {20'h0, pdn, pu})
    `CHK("chmap", pat(1) & 32'h7, {29'h0, chm})
    `CHK("spacing", pat(2) & 32'h3FFF, {18'h0, spc})
    `CHK("lists", {pat(3) & 32'hFFFF, pat(4) & 32'hFFFF}, {16'h0, pub, 16'h0, priv})
    `CHK("counts", pat(5) & 32'hFFFF, {16'h0, npr, npu})
    `CHK("key", {pat(9), pat(8), pat(7), pat(6)}, key)
    `CHK("block", pat(10) & 32'hFFFF, {16'h0, blk})
  endtask
  task automatic t_ro();
    pulse_clk();
    sri <= 9'h1AB;
    sc <= 9'h0CD;
    su <= 1'b1;
    txt <= 32'h1234ABCD;
    txv <= 1'b1;
    rxt <= 32'h5A5AC3C3;
    rxv <= 1'b1;
    pulse_clk();
    su <= 1'b0;
    txv <= 1'b0;
    rxv <= 1'b0;
    txt <= 32'h0;
    rxt <= 32'h0;
    a <= `RLCR_OFF_TX_TAG;
    rd <= 1'b1;
    pulse_clk();
    rd <= 1'b0;
    #1;
    `CHK("tx tag", 32'h1234ABCD, rdata)
    wr_reg(`RLCR_OFF_RX_TAG, 32'hFFFFFFFF);
    rd_chk(`RLCR_OFF_RX_TAG, 32'h5A5AC3C3);
    wr_reg(`RLCR_OFF_ACT_SCAN, 32'h0);
    rd_chk(`RLCR_OFF_ACT_SCAN, 32'h01AB00CD);
  endtask
  task automatic t_cipher();
    wr_reg(`RLCR_OFF_CIPH_CTRL, 32'h3);
    `CHK("cipher", 2'h3, {dec, st})
    wr_reg(`RLCR_OFF_CIPH_CTRL, 32'h2);
    `CHK("cipher", 2'h3, {dec, st})
    rd_chk(`RLCR_OFF_CIPH_CTRL, 32'h3);
    pulse_clk();
    done <= 1'b1;
    pulse_clk();
    done <= 1'b0;
    #1;
    `CHK("cipher", 2'h2, {dec, st})
    wr_reg(`RLCR_OFF_CIPH_CTRL, 32'h1);
    `CHK("cipher", 2'h1, {dec, st})
  endtask
  task automatic t_test();
    wr_reg(`RLCR_OFF_TEST_CTRL, 32'h8000F0AB);
    `CHK("test outs", {4'h0, 9'h155}, {tst, len})
    pulse_clk();
    tm <= 1'b1;
    #1;
    `CHK("test outs", {4'hF, 9'h0AB}, {tst, len})
    wr_reg(`RLCR_OFF_TEST_CTRL, 32'h000000AB);
    `CHK("test outs", {4'h0, 9'h155}, {tst, len})
    wr_reg(`RLCR_OFF_TEST_CTRL, 32'h08000800);
    for (int i = 0; i < 3; i++)
    begin
      pulse_clk();
      txs <= 1'b1;
      rxg <= (i < 2);
    end
    pulse_clk();
    txs <= 1'b0;
    rxg <= 1'b0;
    ab <= 1'b1;
    pulse_clk();
    ab <= 1'b0;
    #1;
    `CHK("totals", {32'h3, 32'h2}, {txtot, rxtot})
    rd_chk(`RLCR_OFF_TX_TOTAL, 32'h3);
    rd_chk(`RLCR_OFF_RX_TOTAL, 32'h2);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_ro();
    t_cipher();
    t_test();
    end_of_test();
  end
endmodule
